// ### rtl/swdc_top.sv
// Standby wake request detector for four external pins with APB registers
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module swdc_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wake pins
  input wire logic wake_pin_0,
  input wire logic wake_pin_1,
  input wire logic wake_pin_2,
  input wire logic wake_pin_3,
  // Wake outputs
  output logic [3:0] wake_request,
  output logic irq
);

  // ==========================================
  // Pin synchronisers
  // Two flops per pin and a delay flop; the second one feeds the level test, the second and the delay flop the edge detector
  // The pins carry no reset; they settle while reset is held
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic [3:0] pin_prev_q;
  wire [3:0] pins_raw = {wake_pin_3, wake_pin_2, wake_pin_1, wake_pin_0};

  always_ff @(posedge mclk) begin
    pin_meta_q <= pins_raw;
    pin_sync_q <= pin_meta_q;
    pin_prev_q <= pin_sync_q;
  end

  // Edges of the synchronised pins, one flag per input
  wire [3:0] rise = pin_sync_q & ~pin_prev_q;
  wire [3:0] fall = ~pin_sync_q & pin_prev_q;

  // ==========================================
  // Register state
  // Per-input mode fields
  logic [2:0] sel0_q;
  logic [2:0] sel1_q;
  logic [2:0] sel2_q;
  logic [2:0] sel3_q;
  logic en0_q;
  logic en1_q;
  logic en2_q;
  logic en3_q;
  logic [1:0] edge0_q;
  logic [1:0] edge1_q;
  logic [1:0] edge2_q;
  logic [1:0] edge3_q;

  // Pending requests, sticky status and mask
  logic [3:0] req_q;
  logic [3:0] stat_q;
  logic [3:0] mask_q;

  // ==========================================
  // APB decode
  // Every register answers after one access cycle, so setup alone selects the read word
  wire setup = psel && !penable;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;

  wire hit_mode = paddr == swdc_pkg::ADDR_MODE;
  wire hit_clear = paddr == swdc_pkg::ADDR_CLEAR;
  wire hit_status = paddr == swdc_pkg::ADDR_STATUS;
  wire hit_mask = paddr == swdc_pkg::ADDR_MASK;
  // Unmapped addresses answer with an error and touch nothing
  wire mapped = hit_mode || hit_clear || hit_status || hit_mask;

  wire wr_mode = wr && hit_mode;
  wire wr_clear = wr && hit_clear;
  wire rd_status = rd && hit_status;
  wire wr_mask = wr && hit_mask;

  // Clear register: bit i drops the pending request of input i
  wire [3:0] clear_bits = wr_clear ? pwdata[3:0] : 4'h0;

  // ==========================================
  // Lane helpers
  // Select field of lane i in a bus word
  function automatic logic [2:0] lane_sel(input logic [31:0] w, input int i);
    lane_sel = w[i*swdc_pkg::LANE_W + swdc_pkg::SEL_POS +: 3];
  endfunction

  // Enable bit of lane i in a bus word
  function automatic logic lane_en(input logic [31:0] w, input int i);
    lane_en = w[i*swdc_pkg::LANE_W + swdc_pkg::EN_POS];
  endfunction

  // Read-back byte of one lane; bit 7 reads zero and bit 1 a fixed filler
  function automatic logic [7:0] lane_pack(input logic [2:0] sel, input logic [1:0] edg,
                                           input logic en);
    lane_pack = 8'h00;
    lane_pack[swdc_pkg::SEL_POS +: 3] = sel;
    lane_pack[swdc_pkg::EDGE_POS +: 2] = edg;
    lane_pack[swdc_pkg::EN_POS] = en;
    lane_pack[1] = swdc_pkg::UNDEF_BIT_VALUE;
  endfunction

  // Request condition of one input for its select code; prohibited codes never match
  function automatic logic detect(input logic [2:0] sel, input logic lvl,
                                  input logic r, input logic f);
    case (sel)
      swdc_pkg::SEL_LOW: detect = !lvl;
      swdc_pkg::SEL_HIGH: detect = lvl;
      swdc_pkg::SEL_FALL: detect = f;
      swdc_pkg::SEL_RISE: detect = r;
      swdc_pkg::SEL_BOTH: detect = r || f;
      default: detect = 1'b0;
    endcase
  endfunction

  // Next edge record: it only gathers edges in both-edge mode, and a clear wins
  function automatic logic [1:0] edge_next(input logic [2:0] sel, input logic [1:0] edg,
                                           input logic en, input logic r, input logic f,
                                           input logic clr);
    edge_next = edg;
    if (sel == swdc_pkg::SEL_BOTH) begin
      edge_next = edg | {f & en, r & en};
    end
    if (clr) begin
      edge_next = swdc_pkg::EDGE_NONE;
    end
  endfunction

  // ==========================================
  // Input 0
  // Write fields, request test, edge record and read-back byte
  wire [2:0] sel0_wr = lane_sel(pwdata, 0);
  wire en0_wr = lane_en(pwdata, 0);
  wire hit0 = en0_q && detect(sel0_q, pin_sync_q[0], rise[0], fall[0]);
  wire [1:0] edge0_d = edge_next(sel0_q, edge0_q, en0_q, rise[0], fall[0], clear_bits[0]);
  wire [7:0] lane0_rd = lane_pack(sel0_q, edge0_q, en0_q);

  // Mode fields of input 0
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel0_q <= swdc_pkg::SEL_RESET;
      en0_q <= 1'b0;
      edge0_q <= swdc_pkg::EDGE_NONE;
    end else begin
      edge0_q <= edge0_d;
      // Only select and enable take write data; edge and filler bits ignore it
      if (wr_mode) begin
        sel0_q <= sel0_wr;
        en0_q <= en0_wr;
      end
    end
  end

  // ==========================================
  // Input 1
  // Write fields, request test, edge record and read-back byte
  wire [2:0] sel1_wr = lane_sel(pwdata, 1);
  wire en1_wr = lane_en(pwdata, 1);
  wire hit1 = en1_q && detect(sel1_q, pin_sync_q[1], rise[1], fall[1]);
  wire [1:0] edge1_d = edge_next(sel1_q, edge1_q, en1_q, rise[1], fall[1], clear_bits[1]);
  wire [7:0] lane1_rd = lane_pack(sel1_q, edge1_q, en1_q);

  // Mode fields of input 1
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel1_q <= swdc_pkg::SEL_RESET;
      en1_q <= 1'b0;
      edge1_q <= swdc_pkg::EDGE_NONE;
    end else begin
      edge1_q <= edge1_d;
      // Only select and enable take write data; edge and filler bits ignore it
      if (wr_mode) begin
        sel1_q <= sel1_wr;
        en1_q <= en1_wr;
      end
    end
  end

  // ==========================================
  // Input 2
  // Write fields, request test, edge record and read-back byte
  wire [2:0] sel2_wr = lane_sel(pwdata, 2);
  wire en2_wr = lane_en(pwdata, 2);
  wire hit2 = en2_q && detect(sel2_q, pin_sync_q[2], rise[2], fall[2]);
  wire [1:0] edge2_d = edge_next(sel2_q, edge2_q, en2_q, rise[2], fall[2], clear_bits[2]);
  wire [7:0] lane2_rd = lane_pack(sel2_q, edge2_q, en2_q);

  // Mode fields of input 2
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel2_q <= swdc_pkg::SEL_RESET;
      en2_q <= 1'b0;
      edge2_q <= swdc_pkg::EDGE_NONE;
    end else begin
      edge2_q <= edge2_d;
      // Only select and enable take write data; edge and filler bits ignore it
      if (wr_mode) begin
        sel2_q <= sel2_wr;
        en2_q <= en2_wr;
      end
    end
  end

  // ==========================================
  // Input 3
  // Write fields, request test, edge record and read-back byte
  wire [2:0] sel3_wr = lane_sel(pwdata, 3);
  wire en3_wr = lane_en(pwdata, 3);
  wire hit3 = en3_q && detect(sel3_q, pin_sync_q[3], rise[3], fall[3]);
  wire [1:0] edge3_d = edge_next(sel3_q, edge3_q, en3_q, rise[3], fall[3], clear_bits[3]);
  wire [7:0] lane3_rd = lane_pack(sel3_q, edge3_q, en3_q);

  // Mode fields of input 3
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel3_q <= swdc_pkg::SEL_RESET;
      en3_q <= 1'b0;
      edge3_q <= swdc_pkg::EDGE_NONE;
    end else begin
      edge3_q <= edge3_d;
      // Only select and enable take write data; edge and filler bits ignore it
      if (wr_mode) begin
        sel3_q <= sel3_wr;
        en3_q <= en3_wr;
      end
    end
  end

  // ==========================================
  // Combined views of the four inputs
  wire [3:0] hit = {hit3, hit2, hit1, hit0};
  wire [31:0] mode_rd = {lane3_rd, lane2_rd, lane1_rd, lane0_rd};
  // Read words of the narrow registers; the clear register and holes read zero
  wire [31:0] status_rd = {28'h0, stat_q};
  wire [31:0] mask_rd = {28'h0, mask_q};
  wire [31:0] rd_mux = hit_mode ? mode_rd :
                       hit_status ? status_rd :
                       hit_mask ? mask_rd : 32'h0;

  // ==========================================
  // Pending requests, held until cleared; a new event beats a same-cycle clear
  // Level modes keep re-setting the request for as long as the level stands
  always_ff @(posedge mclk) begin
    if (rst) begin
      req_q <= 4'h0;
    end else begin
      req_q <= (req_q & ~clear_bits) | hit;
    end
  end

  // Sticky status, cleared by a read of it; the event wins over the read
  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= (rd_status ? 4'h0 : stat_q) | hit;
    end
  end

  // Interrupt mask, same layout as the status word
  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_q <= 4'h0;
    end else if (wr_mask) begin
      mask_q <= pwdata[3:0];
    end
  end

  // ==========================================
  // APB answer: one wait-free access cycle, read data only while ready stands
  // Writes take effect at the access edge, which is always the ready edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // Wake outputs; the interrupt follows the status word one cycle later
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
      wake_request <= 4'h0;
    end else begin
      irq <= |(stat_q & mask_q);
      wake_request <= req_q;
    end
  end
endmodule
`default_nettype wire

// ### rtl/swdc_pkg.sv
// Package with register map, field layout and codes of the standby wake detector
package swdc_pkg;
  // ==========================================
  // Register map
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_CLEAR = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_MASK = 12'h00c;
  // ==========================================
  // Field layout within each byte lane
  localparam int NUM_INPUTS = 4;
  localparam int LANE_W = 8;
  localparam int EN_POS = 0;
  localparam int EDGE_POS = 2;
  localparam int SEL_POS = 4;
  // ==========================================
  // Codes and reset values
  localparam logic [2:0] SEL_LOW = 3'h0;
  localparam logic [2:0] SEL_HIGH = 3'h1;
  localparam logic [2:0] SEL_FALL = 3'h2;
  localparam logic [2:0] SEL_RISE = 3'h3;
  localparam logic [2:0] SEL_BOTH = 3'h4;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [2:0] SEL_RESET = SEL_FALL;
  localparam logic UNDEF_BIT_VALUE = 1'b0;
endpackage

// ### dv/swdc_pins.sv
// Model of the four external wake pins
`timescale 1ns/1ps
`default_nettype none
module swdc_pins (
  input wire logic mclk,
  input wire logic [3:0] lvl,
  output logic [3:0] pin
);
  // Pins are unrelated to the core clock, so they move between its rising edges
  always @(negedge mclk) pin <= lvl;
endmodule
`default_nettype wire

// ### dv/swdc_top_asserts.sv
// Port checker of the wake detector
`timescale 1ns/1ps
`default_nettype none
module swdc_chk (input wire logic mclk, input wire logic rst, input wire logic psel,
  input wire logic penable, input wire logic pwrite, input wire logic [11:0] paddr,
  input wire logic [31:0] prdata, input wire logic pready, input wire logic pslverr,
  input wire logic [3:0] wake_request, input wire logic irq);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire rd = pready && !pwrite;
  wire rm = rd && paddr == 12'h000;
  AST_RDY: assert property (psel && !penable |=> pready)
    else $error("ready late");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_ERR: assert property (pready |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
    else $error("bad error flag");
  AST_IDLE: assert property (!pready |-> prdata == 0 && !pslverr)
    else $error("data outside access");
  AST_RSVD: assert property (rm |-> (prdata & 32'h82828282) == 0)
    else $error("reserved bit set");
  AST_SEL: assert property (rm |-> prdata[6:4] <= 4 && prdata[30:28] <= 4)
    else $error("bad select code");
  AST_CLR: assert property (rd && paddr == 12'h004 |-> prdata == 0)
    else $error("clear reg not zero");
  AST_DROP: assert property (|($past(wake_request) & ~wake_request) |->
    $past(psel && pwrite && pready && paddr == 12'h004, 2))
    else $error("request dropped");
  AST_RSTV: assert property ($past(rst) |-> wake_request == 0 && !irq)
    else $error("not idle after reset");
  cover property (rm);
  cover property (pslverr);
  cover property (irq);
endmodule
bind swdc_top swdc_chk u_swdc_chk (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wake_request(wake_request), .irq(irq));
`default_nettype wire

// ### dv/swdc_top_tb_top.sv
// Self-checking bench of the wake detector
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("FAIL %0t %h %h", $time, a, b); end end
module swdc_top_tb_top;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pslverr, pready, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, x;
  logic [3:0] wake_request, lvl = 4'hf;
  wire [3:0] p;
  logic [32:0] q[$], e;
  int errors = 0, checks_done = 0;
  initial forever #5 mclk = ~mclk;
  swdc_pins u_swdc_pins (.mclk(mclk), .lvl(lvl), .pin(p));
  swdc_top u_swdc_top (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_pin_0(p[0]), .wake_pin_1(p[1]), .wake_pin_2(p[2]),
    .wake_pin_3(p[3]), .wake_request(wake_request), .irq(irq));
  task automatic results();
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] ex);
    int n;
    @(posedge mclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    if (!w) q.push_back(ex);
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do begin @(posedge mclk); n++; end while (!pready && n < 20);
    if (!pready) begin errors++; results(); end
    psel <= 0; penable <= 0;
  endtask
  always @(posedge mclk) if (psel && penable && pready && !pwrite) begin
    e = q.pop_front();
    `CHK({pslverr, prdata}, e)
  end
  initial begin
    r = $urandom(33019);
    repeat (6) @(posedge mclk);
    rst <= 0;
    apb(0, 12'h000, 0, 33'h020202020);
    apb(1, 12'h00c, 32'hf, 0);
    apb(1, 12'h000, 32'hcececece, 0);
    apb(0, 12'h000, 0, 33'h040404040);
    apb(1, 12'h000, 32'h41414141, 0);
    r = $urandom % 15 + 1;
    lvl <= ~r[3:0];
    repeat (8) @(posedge mclk);
    `CHK(wake_request, r[3:0])
    `CHK(irq, 1'b1)
    lvl <= 4'hf;
    repeat (8) @(posedge mclk);
    x = 32'h41414141;
    for (int i = 0; i < 4; i++) if (r[i]) x[8*i+2 +: 2] = 2'h3;
    apb(0, 12'h000, 0, {1'b0, x});
    apb(1, 12'h00c, 0, 0);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    apb(1, 12'h00c, 32'hf, 0);
    apb(0, 12'h008, 0, {29'h0, r[3:0]});
    apb(0, 12'h008, 0, 0);
    `CHK(irq, 1'b0)
    apb(1, 12'h004, 32'hf, 0);
    apb(0, 12'h000, 0, 33'h041414141);
    `CHK(wake_request, 4'h0)
    apb(1, 12'h000, 32'h10101010, 0);
    apb(1, 12'h000, 32'h11111111, 0);
    repeat (4) @(posedge mclk);
    `CHK(wake_request, 4'hf)
    apb(1, 12'h000, 32'h30303030, 0);
    apb(1, 12'h004, 32'hf, 0);
    apb(1, 12'h000, 32'h31313131, 0);
    repeat (4) @(posedge mclk);
    `CHK(wake_request, 4'h0)
    lvl <= ~r[3:0];
    repeat (8) @(posedge mclk);
    lvl <= 4'hf;
    repeat (8) @(posedge mclk);
    `CHK(wake_request, r[3:0])
    rst <= 1;
    repeat (3) @(posedge mclk);
    rst <= 0;
    apb(0, 12'h000, 0, 33'h020202020);
    `CHK(wake_request, 4'h0)
    apb(0, 12'h004, 0, 0);
    apb(0, 12'h010, 0, 33'h100000000);
    @(posedge mclk);
    results();
  end
endmodule
`default_nettype wire
